// >>> rtl/cbe_addr_gen.sv
// Address and pointer write-back for one indirect access.
// Assumes the caller picks the pointer pair and the addressing mode.
module cbe_addr_gen
  import cbe_pkg::*;
(
  input  wire logic [15:0]  base_i,
  input  cbe_mode_type      mode_i,
  input  wire logic [5:0]   disp_i,
  output logic [15:0]       addr_o,
  output logic [15:0]       next_ptr_o
);

  always_comb begin
    addr_o     = base_i;
    next_ptr_o = base_i;
    case (mode_i)
      mode_post_inc: next_ptr_o = base_i + 16'h0001;
      mode_pre_dec: begin
        addr_o     = base_i - 16'h0001;
        next_ptr_o = base_i - 16'h0001;
      end
      mode_disp:     addr_o = base_i + {10'h000, disp_i};
      default: begin
        addr_o     = base_i;
        next_ptr_o = base_i;
      end
    endcase
  end

endmodule : cbe_addr_gen

// >>> rtl/cbe_exec.sv
// Branch and data-transfer execution unit with Avalon-MM register access.
// Assumes a decoder that presents one operation at a time and a data
// memory whose read data is valid in the cycle the read strobe is high.
module cbe_exec
  import cbe_pkg::*;
#(
  parameter int unsigned PC_W = PC_W_DEF
) (
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // Operation issue
  input  wire logic              issue_valid_i,
  output logic                   issue_ready_o,
  input  cbe_op_type             op_i,
  input  cbe_ptr_type            ptr_i,
  input  cbe_mode_type           mode_i,
  input  wire logic [6:0]        br_ofs_i,
  input  wire logic [5:0]        disp_i,
  input  wire logic [15:0]       abs_addr_i,
  input  wire logic [4:0]        reg_idx_i,
  input  wire logic [7:0]        src_data_i,
  // Program counter and fetch refill
  output logic [PC_W-1:0]        pc_o,
  output logic                   fetch_flush_o,
  // Data memory and stack
  output logic [15:0]            dm_addr_o,
  output logic [7:0]             dm_wdata_o,
  output logic                   dm_we_o,
  output logic                   dm_re_o,
  input  wire logic [7:0]        dm_rdata_i,
  // Register file write-back
  output logic                   rf_we_o,
  output logic [4:0]             rf_addr_o,
  output logic [7:0]             rf_data_o,
  output logic [7:0]             flags_o,
  // Avalon-MM slave
  input  wire logic [BUS_AW-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o
);

  typedef enum logic [1:0] {ph_idle, ph_mem, ph_fill} cbe_phase_type;

  typedef struct packed {
    cbe_phase_type   ph;
    logic [PC_W-1:0] pc;
    logic [7:0]      flags;
    logic [15:0]     x;
    logic [15:0]     y;
    logic [15:0]     z;
    logic [15:0]     sp;
    logic [15:0]     dm_addr;
    logic [7:0]      dm_wdata;
    logic            dm_we;
    logic            dm_re;
    logic [4:0]      dest_reg;
    logic            rf_we;
    logic [4:0]      rf_addr;
    logic [7:0]      rf_data;
    logic            flush;
    logic            taken;
    logic            rd_pend;
    logic [31:0]     rdata;
  } cbe_regs_type;

  cbe_regs_type q, d;

  logic [15:0]   sel_ptr;
  logic [15:0]   ag_addr;
  logic [15:0]   ag_next;
  logic          accept;
  logic          cond;
  logic          is_branch;
  logic [PC_W-1:0] br_target;

  // Writes wait while an operation is in flight so state stays coherent
  assign avs_waitrequest_o = (avs_read_i & ~q.rd_pend) |
                             (avs_write_i & (q.ph != ph_idle));
  assign issue_ready_o = (q.ph == ph_idle) & ~avs_write_i;
  assign accept        = issue_valid_i & issue_ready_o;
  assign is_branch     = (op_i <= jump_if_irq_disabled);
  assign br_target     = q.pc + PC_W'({{9{br_ofs_i[6]}}, br_ofs_i})
                         + PC_W'(1);

  always_comb begin
    case (ptr_i)
      ptr_x:   sel_ptr = q.x;
      ptr_y:   sel_ptr = q.y;
      ptr_z:   sel_ptr = q.z;
      default: sel_ptr = q.x;
    endcase
  end

  cbe_addr_gen u_addr_gen (
    .base_i     (sel_ptr),
    .mode_i     (mode_i),
    .disp_i     (disp_i),
    .addr_o     (ag_addr),
    .next_ptr_o (ag_next)
  );

  // Branch condition select
  always_comb begin
    case (op_i)
      jump_if_unsigned_ge:       cond = ~q.flags[FLG_C];
      jump_if_unsigned_lt:       cond =  q.flags[FLG_C];
      jump_if_negative:          cond =  q.flags[FLG_N];
      jump_if_nonnegative:       cond = ~q.flags[FLG_N];
      jump_if_signed_ge:         cond = ~(q.flags[FLG_N] ^ q.flags[FLG_V]);
      jump_if_signed_lt:         cond =  q.flags[FLG_N] ^ q.flags[FLG_V];
      jump_if_half_carry_one:    cond =  q.flags[FLG_H];
      jump_if_half_carry_zero:   cond = ~q.flags[FLG_H];
      jump_if_transfer_bit_one:  cond =  q.flags[FLG_T];
      jump_if_transfer_bit_zero: cond = ~q.flags[FLG_T];
      jump_if_overflow_one:      cond =  q.flags[FLG_V];
      jump_if_overflow_zero:     cond = ~q.flags[FLG_V];
      jump_if_irq_enabled:       cond =  q.flags[FLG_I];
      jump_if_irq_disabled:      cond = ~q.flags[FLG_I];
      default:                   cond = 1'b0;
    endcase
  end

  always_comb begin
    d          = q;
    d.dm_we    = 1'b0;
    d.dm_re    = 1'b0;
    d.rf_we    = 1'b0;
    d.flush    = 1'b0;
    d.rd_pend  = 1'b0;
    // Register reads answer on the second cycle from a flop
    if (avs_read_i & ~q.rd_pend) begin
      d.rd_pend = 1'b1;
      case (avs_address_i)
        OFS_PC:     d.rdata = 32'(q.pc);
        OFS_FLAGS:  d.rdata = {24'h00_0000, q.flags};
        OFS_PTR_X:  d.rdata = {16'h0000, q.x};
        OFS_PTR_Y:  d.rdata = {16'h0000, q.y};
        OFS_PTR_Z:  d.rdata = {16'h0000, q.z};
        OFS_SP:     d.rdata = {16'h0000, q.sp};
        OFS_STATUS: d.rdata = {30'h0000_0000, q.taken, q.ph != ph_idle};
        default:    d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i & (q.ph == ph_idle)) begin
      case (avs_address_i)
        OFS_PC:    d.pc    = avs_writedata_i[PC_W-1:0];
        OFS_FLAGS: d.flags = avs_writedata_i[7:0];
        OFS_PTR_X: d.x     = avs_writedata_i[15:0];
        OFS_PTR_Y: d.y     = avs_writedata_i[15:0];
        OFS_PTR_Z: d.z     = avs_writedata_i[15:0];
        OFS_SP:    d.sp    = avs_writedata_i[15:0];
        default:   d.sp    = q.sp;
      endcase
    end
    case (q.ph)
      ph_idle: begin
        if (accept) begin
          d.pc = q.pc + PC_W'(1);
          if (is_branch) begin
            d.taken = cond;
            if (cond) begin
              d.pc    = br_target;
              d.ph    = ph_fill;
              d.flush = 1'b1;
            end
          end else if (op_i != no_op) begin
            d.ph       = ph_mem;
            d.dm_wdata = src_data_i;
            d.dest_reg = reg_idx_i;
            case (op_i)
              indirect_read_op, offset_read_op: begin
                d.dm_addr = ag_addr;
                d.dm_re   = 1'b1;
              end
              indirect_write_op, offset_write_op: begin
                d.dm_addr = ag_addr;
                d.dm_we   = 1'b1;
              end
              absolute_read_op: begin
                d.dm_addr = abs_addr_i;
                d.dm_re   = 1'b1;
                d.pc      = q.pc + PC_W'(2);
              end
              absolute_write_op: begin
                d.dm_addr = abs_addr_i;
                d.dm_we   = 1'b1;
                d.pc      = q.pc + PC_W'(2);
              end
              push_op: begin
                d.dm_addr = q.sp;
                d.dm_we   = 1'b1;
                d.sp      = q.sp - 16'h0001;
              end
              pop_op: begin
                d.dm_addr = q.sp + 16'h0001;
                d.dm_re   = 1'b1;
                d.sp      = q.sp + 16'h0001;
              end
              default: d.ph = ph_idle;
            endcase
            // Displacement form never writes its pointer back
            if (op_i == indirect_read_op || op_i == indirect_write_op) begin
              case (ptr_i)
                ptr_x:   d.x = ag_next;
                ptr_y:   d.y = ag_next;
                ptr_z:   d.z = ag_next;
                default: d.x = q.x;
              endcase
            end
          end
        end
      end
      ph_mem: begin
        d.ph = ph_idle;
        if (q.dm_re) begin
          d.rf_we   = 1'b1;
          d.rf_addr = q.dest_reg;
          d.rf_data = dm_rdata_i;
        end
      end
      ph_fill: d.ph = ph_idle;
      default: d.ph = ph_idle;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q          <= '0;
      q.ph       <= ph_idle;
      q.flags    <= FLAGS_RST;
      q.x        <= PTR_RST;
      q.y        <= PTR_RST;
      q.z        <= PTR_RST;
      q.sp       <= SP_RST;
    end else begin
      q <= d;
    end
  end

  assign pc_o           = q.pc;
  assign fetch_flush_o  = q.flush;
  assign dm_addr_o      = q.dm_addr;
  assign dm_wdata_o     = q.dm_wdata;
  assign dm_we_o        = q.dm_we;
  assign dm_re_o        = q.dm_re;
  assign rf_we_o        = q.rf_we;
  assign rf_addr_o      = q.rf_addr;
  assign rf_data_o      = q.rf_data;
  assign flags_o        = q.flags;
  assign avs_readdata_o = q.rdata;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic acc_wr;
  assign acc_wr = avs_write_i & ~avs_waitrequest_o;

  sequence s_mem_accept;
    accept && !is_branch && op_i != no_op;
  endsequence

  sequence s_mem_busy_then_free;
    !issue_ready_o ##1 (q.ph == ph_idle);
  endsequence

  property p_branch(logic [4:0] a, logic [4:0] b);
    accept && (op_i == cbe_op_type'(a) || op_i == cbe_op_type'(b)) && cond
      |=> pc_o == $past(br_target) && fetch_flush_o;
  endproperty

  unsigned_branch_a: assert property (
    accept && op_i == jump_if_unsigned_ge
      |=> fetch_flush_o == !$past(flags_o[FLG_C])
  ) else $error("unsigned branch condition wrong");
  sign_branch_a: assert property (
    accept && op_i == jump_if_negative
      |=> fetch_flush_o == $past(flags_o[FLG_N])
  ) else $error("sign branch condition wrong");
  signed_ge_a: assert property (
    accept && op_i == jump_if_signed_ge
      |=> fetch_flush_o == ($past(flags_o[FLG_N]) == $past(flags_o[FLG_V]))
  ) else $error("signed ge condition wrong");
  signed_lt_a: assert property (
    accept && op_i == jump_if_signed_lt
      |=> fetch_flush_o == ($past(flags_o[FLG_N]) != $past(flags_o[FLG_V]))
  ) else $error("signed lt condition wrong");
  half_carry_a: assert property (
    p_branch(jump_if_half_carry_one, jump_if_half_carry_zero)
  ) else $error("half carry branch target wrong");
  transfer_bit_a: assert property (
    p_branch(jump_if_transfer_bit_one, jump_if_transfer_bit_zero)
  ) else $error("transfer bit branch target wrong");
  overflow_branch_a: assert property (
    accept && op_i == jump_if_overflow_zero && !flags_o[FLG_V]
      |=> pc_o == $past(br_target)
  ) else $error("overflow branch not taken");
  irq_branch_a: assert property (
    accept && op_i == jump_if_irq_disabled && flags_o[FLG_I]
      |=> pc_o == $past(pc_o) + PC_W'(1) && issue_ready_o
  ) else $error("irq branch taken wrongly");
  post_inc_load_a: assert property (
    accept && op_i == indirect_read_op && mode_i == mode_post_inc
      |=> dm_re_o && dm_addr_o == $past(sel_ptr)
          ##1 rf_we_o && rf_data_o == $past(dm_rdata_i)
  ) else $error("post increment load wrong");
  pre_dec_load_a: assert property (
    accept && op_i == indirect_read_op && mode_i == mode_pre_dec
      |=> dm_re_o && dm_addr_o == $past(sel_ptr) - 16'h0001
  ) else $error("pre decrement load wrong");
  disp_keeps_ptr_a: assert property (
    accept && op_i == offset_read_op
      |=> sel_ptr == $past(sel_ptr)
          && dm_addr_o == $past(sel_ptr) + {10'h000, $past(disp_i)}
  ) else $error("displacement load moved pointer");
  post_inc_store_a: assert property (
    accept && op_i == indirect_write_op && mode_i == mode_post_inc
      && ptr_i == ptr_x
      |=> dm_we_o && dm_wdata_o == $past(src_data_i)
          && q.x == $past(q.x) + 16'h0001
  ) else $error("post increment store wrong");
  pre_dec_store_a: assert property (
    accept && op_i == indirect_write_op && mode_i == mode_pre_dec
      && ptr_i == ptr_x
      |=> dm_we_o && dm_addr_o == q.x && q.x == $past(q.x) - 16'h0001
  ) else $error("pre decrement store wrong");
  disp_store_a: assert property (
    accept && op_i == offset_write_op && ptr_i == ptr_y
      |=> dm_we_o && q.y == $past(q.y)
  ) else $error("displacement store moved pointer");
  absolute_access_a: assert property (
    accept && (op_i == absolute_read_op || op_i == absolute_write_op)
      |=> dm_addr_o == $past(abs_addr_i) && (dm_re_o || dm_we_o)
  ) else $error("absolute access address wrong");
  stack_push_a: assert property (
    accept && op_i == push_op
      |=> dm_we_o && dm_addr_o == $past(q.sp)
          && q.sp == $past(q.sp) - 16'h0001
  ) else $error("push stack wrong");
  mem_two_cycle_a: assert property (
    s_mem_accept |=> s_mem_busy_then_free
  ) else $error("memory op not two cycles");
  flags_hold_a: assert property (
    accept |=> $stable(flags_o)
  ) else $error("flags changed by operation");
  br_cycles_a: assert property (
    accept && is_branch && cond
      |=> q.ph == ph_fill && !issue_ready_o ##1 q.ph == ph_idle
  ) else $error("taken branch not two cycles");
  unused_acc_a: assert property (
    acc_wr |-> q.ph == ph_idle
  ) else $error("register write during operation");

endmodule : cbe_exec

// >>> rtl/cbe_pkg.sv
// Constants, field layouts and enumerations for the branch and load/store
// execution unit. Assumes a single 25 MHz clock and a decoder upstream.
// Contract
// - Unsigned branches jump to pc+offset+1, same-or-higher on carry clear, lower on carry set.
// - Sign branches jump to pc+offset+1 on negative set (minus) or clear (plus).
// - Signed greater-or-equal jumps only when negative xor overflow is zero.
// - Signed less-than jumps only when negative xor overflow is one.
// - Half-carry branches test the half-carry flag, one variant per level, flags untouched.
// - Transfer-bit branches test the T flag, one variant per level, same target.
// - Overflow branches test the overflow flag, one variant per level.
// - Interrupt-state branches test the global interrupt enable flag.
// - Post-increment load reads at the pointer then adds one to it, two cycles, no flags.
// - Pre-decrement load subtracts one from the pointer, then reads there, two cycles.
// - Displacement load reads at Y or Z plus displacement, pointer kept, two cycles.
// - Post-increment store writes at the pointer then adds one to it, two cycles.
// - Pre-decrement store subtracts one first, then writes there, two cycles.
// - Displacement store writes at Y or Z plus displacement, pointer kept, two cycles.
// - Absolute loads and stores move one byte to or from an address in the instruction, two cycles.
// - Push puts a register on the stack and pop returns the top, two cycles each, no flags.
package cbe_pkg;

  localparam int unsigned PC_W_DEF   = 10;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned BUS_AW     = 5;

  // Register byte offsets
  localparam logic [4:0]  OFS_PC     = 5'h00;
  localparam logic [4:0]  OFS_FLAGS  = 5'h04;
  localparam logic [4:0]  OFS_PTR_X  = 5'h08;
  localparam logic [4:0]  OFS_PTR_Y  = 5'h0C;
  localparam logic [4:0]  OFS_PTR_Z  = 5'h10;
  localparam logic [4:0]  OFS_SP     = 5'h14;
  localparam logic [4:0]  OFS_STATUS = 5'h18;

  // Flag register bit positions
  localparam int unsigned FLG_C      = 0;
  localparam int unsigned FLG_Z      = 1;
  localparam int unsigned FLG_N      = 2;
  localparam int unsigned FLG_V      = 3;
  localparam int unsigned FLG_S      = 4;
  localparam int unsigned FLG_H      = 5;
  localparam int unsigned FLG_T      = 6;
  localparam int unsigned FLG_I      = 7;

  // Status register bit positions
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_TAKEN = 1;

  // Reset values
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [15:0] PTR_RST    = 16'h0000;
  localparam logic [15:0] SP_RST     = 16'h00DF;

  // Cycle counts
  localparam int unsigned MEM_CYCLES = 2;
  localparam int unsigned BR_TAKEN_CYCLES = 2;

  typedef enum logic [4:0] {
    jump_if_unsigned_ge, jump_if_unsigned_lt, jump_if_negative,
    jump_if_nonnegative, jump_if_signed_ge, jump_if_signed_lt,
    jump_if_half_carry_one, jump_if_half_carry_zero,
    jump_if_transfer_bit_one, jump_if_transfer_bit_zero,
    jump_if_overflow_one, jump_if_overflow_zero,
    jump_if_irq_enabled, jump_if_irq_disabled,
    indirect_read_op, offset_read_op, absolute_read_op,
    indirect_write_op, offset_write_op, absolute_write_op,
    push_op, pop_op, no_op
  } cbe_op_type;

  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} cbe_ptr_type;

  typedef enum logic [1:0] {
    mode_plain, mode_post_inc, mode_pre_dec, mode_disp
  } cbe_mode_type;

endpackage : cbe_pkg

// >>> tb/cbe_mem_model.sv
// Behavioural data memory and stack for the execution unit bench.
// Assumes reads are combinational while the read strobe is high.
module cbe_mem_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] dm_addr_i,
  input  wire logic [7:0]  dm_wdata_i,
  input  wire logic        dm_we_i,
  input  wire logic        dm_re_i,
  output logic [7:0]       dm_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h5a;

  // Outside a read the bus shows the inverse, so stale bytes never match
  assign dm_rdata_o = dm_re_i ? mem[dm_addr_i] : ~last_q;

  always @(posedge clk_i) begin
    if (dm_we_i) begin
      mem[dm_addr_i] <= dm_wdata_i;
    end
    if (dm_re_i) begin
      last_q <= mem[dm_addr_i];
    end
  end
endmodule : cbe_mem_model

// >>> tb/cpu_branch_and_load_store_exec_test.sv
// Self-checking bench for the branch and load/store execution unit.
// Assumes the memory model answers reads in the strobe cycle.
module cpu_branch_and_load_store_exec_test
  import cbe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PW = 10;
  logic          clk_i = 1'b0, srst_i = 1'b1, issue_valid_i = 1'b0;
  cbe_op_type    op_i = no_op;
  cbe_ptr_type   ptr_i = ptr_x;
  cbe_mode_type  mode_i = mode_plain;
  logic [6:0]    br_ofs_i = 7'h00;
  logic [5:0]    disp_i = 6'h00;
  logic [15:0]   abs_addr_i = 16'h0000;
  logic [4:0]    reg_idx_i = 5'h00, avs_address_i = 5'h00;
  logic [7:0]    src_data_i = 8'h00, dm_rdata_i, dm_wdata_o, rf_data_o;
  logic [7:0]    flags_o, fl, dv;
  logic          avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0]   avs_writedata_i = 32'h0000_0000, avs_readdata_o;
  logic          issue_ready_o, fetch_flush_o, dm_we_o, dm_re_o, rf_we_o;
  logic          avs_waitrequest_o, tk;
  logic [PW-1:0] pc_o, exp_pc = '0;
  logic [15:0]   dm_addr_o, rx, rp;
  logic [4:0]    rf_addr_o;
  logic [6:0]    ofs;
  logic [7:0]    d [0:2];
  logic [31:0]   q_rf [$], q_wr [$], q_br [$];
  int            n_errors = 0, tests_run = 0, cycles = 0;

  cbe_exec #(.PC_W(PW)) DUT (.clk_i(clk_i), .srst_i(srst_i),
    .issue_valid_i(issue_valid_i), .issue_ready_o(issue_ready_o),
    .op_i(op_i), .ptr_i(ptr_i), .mode_i(mode_i), .br_ofs_i(br_ofs_i),
    .disp_i(disp_i), .abs_addr_i(abs_addr_i), .reg_idx_i(reg_idx_i),
    .src_data_i(src_data_i), .pc_o(pc_o), .fetch_flush_o(fetch_flush_o),
    .dm_addr_o(dm_addr_o), .dm_wdata_o(dm_wdata_o), .dm_we_o(dm_we_o),
    .dm_re_o(dm_re_o), .dm_rdata_i(dm_rdata_i), .rf_we_o(rf_we_o),
    .rf_addr_o(rf_addr_o), .rf_data_o(rf_data_o), .flags_o(flags_o),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o));

  cbe_mem_model mem (.clk_i(clk_i), .dm_addr_i(dm_addr_o),
    .dm_wdata_i(dm_wdata_o), .dm_we_i(dm_we_o), .dm_re_i(dm_re_o),
    .dm_rdata_o(dm_rdata_i));

  always #20 clk_i = ~clk_i;

  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_write_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    check(avs_readdata_o, e);
  endtask : bus_rd

  // Counts cycles from accept until ready returns, then checks the pc
  task automatic run_op(input cbe_op_type op, input cbe_ptr_type p,
      input cbe_mode_type m, input logic [6:0] o, input logic [5:0] q,
      input logic [15:0] a, input logic [7:0] v, input logic [4:0] r,
      input int cyc);
    int n;
    @(posedge clk_i);
    issue_valid_i <= 1'b1;
    op_i <= op;
    ptr_i <= p;
    mode_i <= m;
    br_ofs_i <= o;
    disp_i <= q;
    abs_addr_i <= a;
    src_data_i <= v;
    reg_idx_i <= r;
    do @(posedge clk_i); while (issue_ready_o !== 1'b1);
    issue_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (issue_ready_o !== 1'b1 && n < 20);
    check(n, cyc);
    check(pc_o, exp_pc);
  endtask : run_op

  task automatic rd(input cbe_op_type op, input cbe_ptr_type p,
      input cbe_mode_type m, input logic [5:0] q, input logic [15:0] a,
      input logic [7:0] e);
    logic [4:0] r;
    r = 5'($urandom);
    q_rf.push_back({19'h0, r, e});
    exp_pc += (op == absolute_read_op) ? 10'h002 : 10'h001;
    run_op(op, p, m, 7'h00, q, a, 8'h00, r, 2);
  endtask : rd

  task automatic wr(input cbe_op_type op, input cbe_ptr_type p,
      input cbe_mode_type m, input logic [5:0] q, input logic [15:0] a,
      input logic [15:0] wa, input logic [7:0] v);
    q_wr.push_back({8'h00, wa, v});
    exp_pc += (op == absolute_write_op) ? 10'h002 : 10'h001;
    run_op(op, p, m, 7'h00, q, a, v, 5'h00, 2);
  endtask : wr

  function automatic logic taken(input cbe_op_type op, input logic [7:0] f);
    case (op)
      jump_if_unsigned_ge:       return !f[FLG_C];
      jump_if_unsigned_lt:       return f[FLG_C];
      jump_if_negative:          return f[FLG_N];
      jump_if_nonnegative:       return !f[FLG_N];
      jump_if_signed_ge:         return !(f[FLG_N] ^ f[FLG_V]);
      jump_if_signed_lt:         return f[FLG_N] ^ f[FLG_V];
      jump_if_half_carry_one:    return f[FLG_H];
      jump_if_half_carry_zero:   return !f[FLG_H];
      jump_if_transfer_bit_one:  return f[FLG_T];
      jump_if_transfer_bit_zero: return !f[FLG_T];
      jump_if_overflow_one:      return f[FLG_V];
      jump_if_overflow_zero:     return !f[FLG_V];
      jump_if_irq_enabled:       return f[FLG_I];
      default:                   return !f[FLG_I];
    endcase
  endfunction : taken

  // Results are matched in order against what the driver expected
  always @(posedge clk_i) begin
    if (srst_i === 1'b0) begin
      if (rf_we_o === 1'b1) begin
        check({19'h0, rf_addr_o, rf_data_o},
              q_rf.size() > 0 ? q_rf.pop_front() : 32'hdead_beef);
      end
      if (dm_we_o === 1'b1) begin
        check({8'h00, dm_addr_o, dm_wdata_o},
              q_wr.size() > 0 ? q_wr.pop_front() : 32'hdead_beef);
      end
      if (fetch_flush_o === 1'b1) begin
        check(pc_o,
              q_br.size() > 0 ? q_br.pop_front() : 32'hdead_beef);
      end
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'h37e3));
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    bus_rd(OFS_PC, 32'h0000_0000);
    bus_rd(OFS_FLAGS, 32'h0000_0000);
    bus_rd(OFS_PTR_X, 32'h0000_0000);
    bus_rd(OFS_SP, 32'h0000_00df);
    bus_wr(5'h1c, 32'hffff_ffff);
    bus_rd(5'h1c, 32'h0000_0000);
    // Each flag pattern and its inverse, so every branch except signed ge/lt (N xor V is unchanged) goes both ways
    for (int i = 0; i < 14; i++) begin
      for (int k = 0; k < 2; k++) begin
        fl = (k == 0) ? 8'($urandom) : ~fl;
        bus_wr(OFS_FLAGS, {24'h00_0000, fl});
        ofs = 7'($urandom);
        tk = taken(cbe_op_type'(i), fl);
        exp_pc = exp_pc + 10'h001 + (tk ? {{(PW-7){ofs[6]}}, ofs} : '0);
        if (tk) begin
          q_br.push_back(32'(exp_pc));
        end
        run_op(cbe_op_type'(i), ptr_x, mode_plain, ofs, 6'h00, 16'h0000,
               8'h00, 5'h00, tk ? 2 : 1);
      end
    end
    bus_rd(OFS_STATUS, {30'h0000_0000, tk, 1'b0});
    bus_rd(OFS_FLAGS, {24'h00_0000, fl});
    rx = 16'($urandom);
    foreach (d[i]) d[i] = 8'($urandom);
    bus_wr(OFS_PTR_X, {16'h0000, rx});
    wr(indirect_write_op, ptr_x, mode_post_inc, 0, 0, rx, d[0]);
    wr(indirect_write_op, ptr_x, mode_post_inc, 0, 0, rx + 1, d[1]);
    rd(indirect_read_op, ptr_x, mode_pre_dec, 0, 0, d[1]);
    rd(indirect_read_op, ptr_x, mode_pre_dec, 0, 0, d[0]);
    rd(indirect_read_op, ptr_x, mode_post_inc, 0, 0, d[0]);
    bus_rd(OFS_PTR_X, {16'h0000, rx + 16'h0001});
    wr(indirect_write_op, ptr_x, mode_pre_dec, 0, 0, rx, d[2]);
    rd(indirect_read_op, ptr_x, mode_plain, 0, 0, d[2]);
    bus_rd(OFS_PTR_X, {16'h0000, rx});
    for (int j = 0; j < 2; j++) begin
      rp = 16'($urandom);
      dv = 8'($urandom);
      bus_wr(j ? OFS_PTR_Z : OFS_PTR_Y, {16'h0000, rp});
      wr(offset_write_op, j ? ptr_z : ptr_y, mode_disp, j ? 6'h3f : 6'h00,
         0, rp + (j ? 16'h003f : 16'h0000), dv);
      rd(offset_read_op, j ? ptr_z : ptr_y, mode_disp, j ? 6'h3f : 6'h00,
         0, dv);
      bus_rd(j ? OFS_PTR_Z : OFS_PTR_Y, {16'h0000, rp});
    end
    rp = 16'($urandom);
    wr(absolute_write_op, ptr_x, mode_plain, 0, rp, rp, d[1]);
    rd(absolute_read_op, ptr_x, mode_plain, 0, rp, d[1]);
    wr(push_op, ptr_x, mode_plain, 0, 0, 16'h00df, d[2]);
    rd(pop_op, ptr_x, mode_plain, 0, 0, d[2]);
    bus_rd(OFS_SP, 32'h0000_00df);
    bus_rd(OFS_FLAGS, {24'h00_0000, fl});
    repeat (4) @(posedge clk_i);
    check(q_rf.size() + q_wr.size() + q_br.size(), 0);
    final_report();
  end
endmodule : cpu_branch_and_load_store_exec_test
